// ---- verilog/ddrx_pkg.sv ----
// Purpose: Shared constants for the DDR transfer timing configuration block
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes: Field positions and reset values of the transfer configuration word
package ddrx_pkg;
  // ==========================================================
  // Register map
  localparam logic [3:0] ADDR_XFER_CFG = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;

  // ==========================================================
  // Transfer configuration fields
  localparam int BYTE_ORDER_BIT = 31;
  localparam int BURST_LIMIT_LSB = 24;
  localparam int READ_EN_DLY_LSB = 16;
  localparam int READ_DATA_WAIT_LSB = 4;
  localparam int WRITE_REQ_WAIT_LSB = 0;
  localparam int FIELD_W = 4;
  localparam logic [31:0] XFER_CFG_RESET = 32'h0400_0000;
  localparam logic [31:0] XFER_CFG_MASK = 32'h8f0f_00ff;

  // ==========================================================
  // Bus answers and channel count
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int NUM_WAITS = 3;
endpackage

// ---- verilog/ddrx_wait_timer.sv ----
// Purpose: One minimum-wait timer started by a command issue
// Assumes: Start is a one-cycle pulse on core_clk
// Notes: A count of zero behaves as a count of one
`timescale 1ns/1ps
module ddrx_wait_timer (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [3:0] waitCount,
  output logic fire
);
  logic [3:0] remain_reg;
  logic busy_reg;

  // Load on start, count down while busy; a restart reloads
  always_ff @(posedge core_clk) begin
    if (rst) begin
      remain_reg <= 4'h0;
      busy_reg <= 1'b0;
    end else if (start) begin
      remain_reg <= (waitCount == 4'h0) ? 4'h1 : waitCount;
      busy_reg <= 1'b1;
    end else if (busy_reg) begin
      remain_reg <= remain_reg - 4'h1;
      busy_reg <= (remain_reg != 4'h1);
    end
  end

  // Fires in the last cycle of the wait
  assign fire = busy_reg && (remain_reg == 4'h1) && !start;
endmodule

// ---- verilog/ddrx_transfer_cfg.sv ----
// Purpose: Transfer configuration register and PHY handshake timing
// Assumes: Command and PHY signals come from logic on core_clk
// Notes: AXI4-Lite slave, one write and one read in flight at most
// What this block does
// - Bit 31 set selects big-endian data
// - Burst-limit field caps commands accepted per burst
// - Read enable waits read-enable delay after read
// - Read data expected after read-data wait
// - Write data request waits write-request delay
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module ddrx_transfer_cfg (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic burstMode,
  input wire logic burstDone,
  input wire logic cmdPush,
  output logic cmdPushReady,
  input wire logic phyCmdIssue,
  input wire logic phyCmdIsRead,
  output logic phyReadEnable,
  output logic readDataDue,
  output logic nextDataRequest,
  input wire logic [31:0] wrData,
  output logic [31:0] phyWrData,
  input wire logic [31:0] phyRdData,
  output logic [31:0] rdData
);
  // ==========================================================
  // Configuration fields
  logic [31:0] xferCfg_reg;
  logic byteOrderSel;
  logic [3:0] burstCommandLimit;
  logic [3:0] readEnableDelay;
  logic [3:0] readDataWait;
  logic [3:0] writeRequestWait;
  logic [3:0] burstCount_reg;
  localparam int NUM_W = ddrx_pkg::NUM_WAITS;
  logic [NUM_W-1:0] waitStart;
  logic [NUM_W-1:0] waitFire;
  logic [3:0] waitCount [NUM_W];

  assign byteOrderSel = xferCfg_reg[ddrx_pkg::BYTE_ORDER_BIT];
  assign burstCommandLimit = xferCfg_reg[ddrx_pkg::BURST_LIMIT_LSB +: ddrx_pkg::FIELD_W];
  assign readEnableDelay = xferCfg_reg[ddrx_pkg::READ_EN_DLY_LSB +: ddrx_pkg::FIELD_W];
  assign readDataWait = xferCfg_reg[ddrx_pkg::READ_DATA_WAIT_LSB +: ddrx_pkg::FIELD_W];
  assign writeRequestWait = xferCfg_reg[ddrx_pkg::WRITE_REQ_WAIT_LSB +: ddrx_pkg::FIELD_W];

  // ==========================================================
  // AXI4-Lite write channel
  logic awHeld_reg;
  logic wHeld_reg;
  logic [3:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic doWrite;

  assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_reg && !s_axi_bvalid;
  assign doWrite = awHeld_reg && wHeld_reg;

  // Address and data are caught in either order
  always_ff @(posedge core_clk) begin
    if (rst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 4'h0;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_reg <= 1'b0;
      end
    end
  end

  // Write response, error on any address but the configuration word
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ddrx_pkg::RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (awAddr_reg == ddrx_pkg::ADDR_XFER_CFG) ? ddrx_pkg::RESP_OKAY
                                                             : ddrx_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration word with byte strobes; unimplemented bits stay zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      xferCfg_reg <= ddrx_pkg::XFER_CFG_RESET;
    end else if (doWrite && awAddr_reg == ddrx_pkg::ADDR_XFER_CFG) begin
      for (int b = 0; b < 4; b++) begin
        if (wStrb_reg[b]) begin
          xferCfg_reg[8*b +: 8] <= wData_reg[8*b +: 8] & ddrx_pkg::XFER_CFG_MASK[8*b +: 8];
        end
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  assign s_axi_arready = !s_axi_rvalid;

  // Status word shows the burst count and the wait timers firing this cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ddrx_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= ddrx_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        ddrx_pkg::ADDR_XFER_CFG: s_axi_rdata <= xferCfg_reg;
        ddrx_pkg::ADDR_STATUS: s_axi_rdata <= {25'h0, burstCount_reg, waitFire};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= ddrx_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Burst command limit; a limit of zero leaves bursts uncapped
  assign cmdPushReady = !burstMode || burstCommandLimit == 4'h0
                        || burstCount_reg < burstCommandLimit;

  always_ff @(posedge core_clk) begin
    if (rst || burstDone || !burstMode) begin
      burstCount_reg <= 4'h0;
    end else if (cmdPush && cmdPushReady) begin
      burstCount_reg <= burstCount_reg + 4'h1;
    end
  end

  // ==========================================================
  // Handshake timers, one per delay field
  assign waitStart = {phyCmdIssue && !phyCmdIsRead, {2{phyCmdIssue && phyCmdIsRead}}};
  assign waitCount[0] = readEnableDelay;
  assign waitCount[1] = readDataWait;
  assign waitCount[2] = writeRequestWait;

  generate
    for (genvar i = 0; i < NUM_W; i++) begin : gWait
      // Counts whole core_clk cycles; zero waits one pipeline cycle
      ddrx_wait_timer uTimer (
        .core_clk(core_clk),
        .rst(rst),
        .start(waitStart[i]),
        .waitCount(waitCount[i]),
        .fire(waitFire[i])
      );
    end
  endgenerate

  assign phyReadEnable = waitFire[0];
  assign readDataDue = waitFire[1];
  assign nextDataRequest = waitFire[2];

  // ==========================================================
  // Byte order of the data paths
  function automatic logic [31:0] ddrx_swap(input logic [31:0] d, input logic swap);
    ddrx_swap = swap ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
  endfunction

  always_ff @(posedge core_clk) begin
    if (rst) begin
      phyWrData <= 32'h0000_0000;
      rdData <= 32'h0000_0000;
    end else begin
      phyWrData <= ddrx_swap(wrData, byteOrderSel);
      rdData <= ddrx_swap(phyRdData, byteOrderSel);
    end
  end

  // ==========================================================
  // Checks: cycles since last issue of each kind
  logic [4:0] sinceRd_reg;
  logic [4:0] sinceWr_reg;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sinceRd_reg <= 5'h1f;
      sinceWr_reg <= 5'h1f;
    end else begin
      sinceRd_reg <= (phyCmdIssue && phyCmdIsRead) ? 5'h0
                     : (sinceRd_reg == 5'h1f ? sinceRd_reg : sinceRd_reg + 5'h1);
      sinceWr_reg <= (phyCmdIssue && !phyCmdIsRead) ? 5'h0
                     : (sinceWr_reg == 5'h1f ? sinceWr_reg : sinceWr_reg + 5'h1);
    end
  end

  a_byte_order: assert property (@(posedge core_clk) disable iff (rst)
    ##1 phyWrData == ddrx_swap($past(wrData), $past(byteOrderSel)))
    else $error("write data byte order wrong");
  a_burst_cap: assert property (@(posedge core_clk) disable iff (rst)
    burstMode && burstCommandLimit != 4'h0 && burstCount_reg >= burstCommandLimit
    |-> !cmdPushReady)
    else $error("burst limit exceeded");
  a_read_enable_wait: assert property (@(posedge core_clk) disable iff (rst)
    phyReadEnable |-> sinceRd_reg + 5'h1 >= {1'b0, readEnableDelay})
    else $error("read enable too early");
  a_read_enable_due: assert property (@(posedge core_clk) disable iff (rst)
    phyCmdIssue && phyCmdIsRead && readEnableDelay == 4'h3
    ##1 !phyCmdIssue [*3] |-> phyReadEnable)
    else $error("read enable missing");
  a_read_data_wait: assert property (@(posedge core_clk) disable iff (rst)
    readDataDue |-> sinceRd_reg + 5'h1 >= {1'b0, readDataWait})
    else $error("read data expected too early");
  a_write_req_wait: assert property (@(posedge core_clk) disable iff (rst)
    nextDataRequest |-> sinceWr_reg + 5'h1 >= {1'b0, writeRequestWait})
    else $error("write request too early");
  a_zero_wait: assert property (@(posedge core_clk) disable iff (rst)
    phyCmdIssue && !phyCmdIsRead && writeRequestWait == 4'h0 |=> nextDataRequest)
    else $error("zero wait not one cycle");
  a_bresp_slverr: assert property (@(posedge core_clk) disable iff (rst)
    doWrite && awAddr_reg != ddrx_pkg::ADDR_XFER_CFG |=> s_axi_bresp == ddrx_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");

  c_read_cmd: cover property (@(posedge core_clk) phyCmdIssue && phyCmdIsRead ##[1:16] readDataDue);
  c_write_cmd: cover property (@(posedge core_clk) phyCmdIssue && !phyCmdIsRead
    ##[1:16] nextDataRequest);
  c_burst_full: cover property (@(posedge core_clk) burstMode && cmdPush && !cmdPushReady);
endmodule

// ---- sim/ddrx_phy_model.sv ----
// Purpose: Behavioural PHY and command issue side of the block
// Assumes: Issue requests come from the bench on core_clk
// Notes: Read data bus toggles every cycle while nothing drives it
`timescale 1ns/1ps
module ddrx_phy_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic issueReq,
  input wire logic issueRd,
  input wire logic holdData,
  input wire logic [31:0] rdWord,
  output logic phyCmdIssue,
  output logic phyCmdIsRead,
  output logic [31:0] phyRdData
);
  // ==========================================================
  // Command issue, one-cycle pulse per request
  always_ff @(posedge core_clk) begin
    phyCmdIssue <= issueReq && !rst;
    phyCmdIsRead <= issueRd;
  end

  // Returned read data, inverted pattern while undriven
  always_ff @(posedge core_clk) begin
    if (rst) begin
      phyRdData <= 32'h0;
    end else begin
      phyRdData <= holdData ? rdWord : ~phyRdData;
    end
  end
endmodule

// ---- sim/test_ddrx_transfer_cfg.sv ----
// Purpose: Self-checking bench for the transfer timing block
// Assumes: AXI4-Lite master tasks, PHY model on the far side
// Notes: Delays are counted from the command issue cycle
`timescale 1ns/1ps
module test_ddrx_transfer_cfg;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] wrData = 32'h0;
  logic [31:0] rdWord = 32'h0;
  logic burstMode = 1'h0;
  logic burstDone = 1'h0;
  logic cmdPush = 1'h0;
  logic issueReq = 1'h0;
  logic issueRd = 1'h0;
  logic holdData = 1'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic cmdPushReady, phyCmdIssue, phyCmdIsRead;
  logic phyReadEnable, readDataDue, nextDataRequest;
  logic [31:0] s_axi_rdata, phyWrData, phyRdData, rdData, got;
  logic [2:0] pulses;
  logic [3:0] dv [5] = '{4'h0, 4'h3, 4'h7, 4'ha, 4'hf};
  int nErrors = 0;
  int numChecks = 0;

  // ==========================================================
  // Clock, design and far side
  always #5 core_clk = ~core_clk;
  ddrx_transfer_cfg DUT (
    .core_clk(core_clk),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .burstMode(burstMode),
    .burstDone(burstDone),
    .cmdPush(cmdPush),
    .cmdPushReady(cmdPushReady),
    .phyCmdIssue(phyCmdIssue),
    .phyCmdIsRead(phyCmdIsRead),
    .phyReadEnable(phyReadEnable),
    .readDataDue(readDataDue),
    .nextDataRequest(nextDataRequest),
    .wrData(wrData),
    .phyWrData(phyWrData),
    .phyRdData(phyRdData),
    .rdData(rdData)
  );
  ddrx_phy_model phy (
    .core_clk(core_clk),
    .rst(rst),
    .issueReq(issueReq),
    .issueRd(issueRd),
    .holdData(holdData),
    .rdWord(rdWord),
    .phyCmdIssue(phyCmdIssue),
    .phyCmdIsRead(phyCmdIsRead),
    .phyRdData(phyRdData)
  );
  assign pulses = {nextDataRequest, readDataDue, phyReadEnable};

  // Compare one value and count it
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Verdict and end of run
  task finish_test;
    $display("checks %0d errors %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Bus write, both halves offered together
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    // Waits for the answer; only the watchdog ends a hang
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  // Bus read, data taken at the rvalid edge
  task rd(input logic [3:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    // Waits for the answer; only the watchdog ends a hang
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  // Issue one command and count cycles until the chosen pulse
  task dly(input logic isRd, input int idx, input logic [3:0] d);
    int n;
    @(posedge core_clk);
    issueReq <= 1'h1;
    issueRd <= isRd;
    @(posedge core_clk);
    issueReq <= 1'h0;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (pulses[idx] !== 1'h1 && n < 40);
    chk("delay", 32'(n), (d == 4'h0) ? 32'h1 : {28'h0, d});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'h0;
    rd(ddrx_pkg::ADDR_XFER_CFG, got, ddrx_pkg::RESP_OKAY);
    chk("reset", got, 32'h0400_0000);
    wr(ddrx_pkg::ADDR_XFER_CFG, 32'hffff_ffff, ddrx_pkg::RESP_OKAY);
    rd(ddrx_pkg::ADDR_XFER_CFG, got, ddrx_pkg::RESP_OKAY);
    chk("mask", got, 32'h8f0f_00ff);
    // Only the low byte lane is written
    s_axi_wstrb <= 4'h1;
    wr(ddrx_pkg::ADDR_XFER_CFG, 32'h0000_0000, ddrx_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(ddrx_pkg::ADDR_XFER_CFG, got, ddrx_pkg::RESP_OKAY);
    chk("strobe", got, 32'h8f0f_0000);
    wr(ddrx_pkg::ADDR_STATUS, 32'h1, ddrx_pkg::RESP_SLVERR);
    wr(4'h8, 32'h1, ddrx_pkg::RESP_SLVERR);
    rd(4'hc, got, ddrx_pkg::RESP_SLVERR);
    // Each delay field at distinct values, zero included for the read-enable delay and the write-request wait only
    foreach (dv[i]) begin
      wr(ddrx_pkg::ADDR_XFER_CFG, {12'h0, dv[i], 8'h0, dv[i] ^ 4'h5, dv[i] ^ 4'ha},
        ddrx_pkg::RESP_OKAY);
      dly(1'h1, 0, dv[i]);
      dly(1'h1, 1, dv[i] ^ 4'h5);
      dly(1'h0, 2, dv[i] ^ 4'ha);
    end
    // Byte order both ways on both data paths
    holdData <= 1'h1;
    for (int b = 0; b < 2; b++) begin
      wr(ddrx_pkg::ADDR_XFER_CFG, {b[0], 31'h0}, ddrx_pkg::RESP_OKAY);
      wrData <= 32'h1122_3344;
      rdWord <= 32'ha1b2_c3d4;
      repeat (3) @(posedge core_clk);
      #1;
      chk("wr order", phyWrData, b ? 32'h4433_2211 : 32'h1122_3344);
      chk("rd order", rdData, b ? 32'hd4c3_b2a1 : 32'ha1b2_c3d4);
    end
    // Three back-to-back pushes offered against a limit of two
    wr(ddrx_pkg::ADDR_XFER_CFG, 32'h0200_0000, ddrx_pkg::RESP_OKAY);
    burstMode <= 1'h1;
    @(posedge core_clk);
    cmdPush <= 1'h1;
    repeat (3) @(posedge core_clk);
    cmdPush <= 1'h0;
    #1;
    chk("cap", {31'h0, cmdPushReady}, 32'h0);
    // Third push is refused, so the count stays at the limit
    rd(ddrx_pkg::ADDR_STATUS, got, ddrx_pkg::RESP_OKAY);
    chk("count", got, 32'h0000_0010);
    @(posedge core_clk);
    burstDone <= 1'h1;
    @(posedge core_clk);
    burstDone <= 1'h0;
    #1;
    chk("cap clear", {31'h0, cmdPushReady}, 32'h1);
    finish_test;
  end

  // Watchdog against a hung handshake
  initial begin
    #100000;
    nErrors++;
    finish_test;
  end
endmodule
